// ==== bench/hbpwm_stage_model.sv ====
// power stage model: two bridge legs driven by outputs 0..3.
// assumes high-side gates conduct while low, low-side gates while high.
`timescale 1ns/1ps
module hbpwm_stage_model (
  // gate pins
  input wire logic gate_a_high_n,
  input wire logic gate_a_low,
  input wire logic gate_b_high_n,
  input wire logic gate_b_low,
  // leg status
  output logic shoot_through
);
  // ************
  // leg conduction
  // ************
  // both switches of one leg closed would short the supply
  assign shoot_through = (!gate_a_high_n && gate_a_low) ||
    (!gate_b_high_n && gate_b_low);
endmodule

// ==== bench/hbpwm_top_properties.sv ====
// checker of hbpwm_top: apb answer, trip and output forcing.
// assumes it is bound to hbpwm_top and sees only its ports.
`timescale 1ns/1ps
module hbpwm_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // trip and outputs
  input wire logic trip_input_n,
  input wire logic channel_out_0,
  input wire logic channel_out_1,
  input wire logic channel_out_2,
  input wire logic channel_out_3,
  input wire logic pin_pwm_function,
  input wire logic trip_irq
);
  // ************
  // control shadow
  // ************
  logic [15:0] ctrl_q;
  logic wr_done;
  logic clr_wr;
  logic [3:0] quad;
  assign wr_done = psel && penable && pready && pwrite;
  assign clr_wr = wr_done && paddr == hbpwm_pkg::TRIP_INTERRUPT_CLEAR_ADDR;
  assign quad = {channel_out_0, channel_out_1, channel_out_2, channel_out_3};
  // a trip clears bit 0 unseen here, so bit 0 is trusted only when low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= hbpwm_pkg::MAIN_CONTROL_RESET;
    end else if (wr_done && paddr == hbpwm_pkg::MAIN_CONTROL_ADDR) begin
      ctrl_q <= pwdata[15:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable && !pready && clk_en;
  endsequence
  sequence s_high_off;
    (ctrl_q[1] && ctrl_q[4]) [*3];
  endsequence
  sequence s_bridge_off;
    (ctrl_q[1] && !ctrl_q[4] && !ctrl_q[9]) [*3];
  endsequence
  sequence s_std_off;
    (!ctrl_q[1] && !ctrl_q[0]) [*3];
  endsequence
  AST_ANSWER: assert property (s_access |=> pready)
    else $error("pready not one cycle after access");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_READY_ACCESS: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero while idle");
  AST_PIN_FUNC: assert property (pin_pwm_function)
    else $error("shared pins left pwm function");
  AST_TRIP_SET: assert property (ctrl_q[10] && !trip_input_n |=> trip_irq)
    else $error("trip not raised");
  AST_TRIP_CLEAR: assert property (clr_wr && trip_input_n |=> !trip_irq)
    else $error("trip not cleared by write");
  AST_IRQ_HOLD: assert property (trip_irq && !clr_wr |=> trip_irq)
    else $error("trip pending dropped alone");
  AST_HIGH_OFF: assert property (s_high_off |-> quad == 4'hA)
    else $error("high side off pattern wrong");
  AST_BRIDGE_OFF: assert property (s_bridge_off |-> quad == 4'hF)
    else $error("bridge off pattern wrong");
  AST_STD_OFF: assert property (s_std_off |-> quad == 4'h0)
    else $error("disabled outputs not low");
endmodule
bind hbpwm_top hbpwm_props i_props (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .trip_input_n(trip_input_n),
  .channel_out_0(channel_out_0), .channel_out_1(channel_out_1),
  .channel_out_2(channel_out_2), .channel_out_3(channel_out_3),
  .pin_pwm_function(pin_pwm_function), .trip_irq(trip_irq));

// ==== bench/testbench.sv ====
// self-checking bench of hbpwm_top: apb tasks, pattern and trip tests.
// assumes the stage model and the property checker are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
  err_total++; $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic trip_input_n = 1'b1;
  logic [31:0] prdata, r;
  logic pready, pslverr, pin_pwm_function, trip_irq, shoot, e;
  logic [5:0] outs;
  int err_total = 0;
  int check_count = 0;
  int hi, ri;
  logic [15:0] ctl [7] = '{16'h0003, 16'h0013, 16'h0203, 16'h0207,
    16'h0223, 16'h0227, 16'h0202};
  // pair 0 runs with its high wave up and low wave down, so each of the
  // four direction patterns below differs from the others
  logic [3:0] pat [7] = '{4'hF, 4'hA, 4'h2, 4'h8, 4'hB, 4'hE, 4'hF};
  always #2.5 pclk = ~pclk;
  // clock enable stays high: stalling is not exercised here
  hbpwm_top i_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trip_input_n(trip_input_n), .channel_out_0(outs[0]),
    .channel_out_1(outs[1]), .channel_out_2(outs[2]),
    .channel_out_3(outs[3]), .channel_out_4(outs[4]),
    .channel_out_5(outs[5]), .pin_pwm_function(pin_pwm_function),
    .trip_irq(trip_irq));
  hbpwm_stage_model i_stage (.gate_a_high_n(outs[0]), .gate_a_low(outs[1]),
    .gate_b_high_n(outs[2]), .gate_b_low(outs[3]), .shoot_through(shoot));
  // ************
  // tasks
  // ************
  task automatic apb(input logic w, input logic [31:0] a, d,
      output logic [31:0] rv, output logic ev);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: a missing answer is ended by the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, d);
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [31:0] a, x, input string s);
    apb(1'b0, a, 32'h0, r, e);
    `CHK(s, x, r)
  endtask
  task automatic meas(input int i, input int c);
    logic p;
    p = outs[i];
    hi = 0;
    ri = 0;
    repeat (c) begin
      @(negedge pclk);
      hi += outs[i];
      if (outs[i] && !p) ri++;
      p = outs[i];
    end
  endtask
  task conclude;
    if (err_total == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ************
  // tests
  // ************
  initial begin
    #300000;
    err_total++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wr(hbpwm_pkg::PAIR1_PERIOD_LENGTH_ADDR, 32'h9);
    `CHK("side off outs", 4'hA, {outs[0], outs[1], outs[2], outs[3]})
    `CHK("pin func", 1'b1, pin_pwm_function)
    rd(hbpwm_pkg::MAIN_CONTROL_ADDR, 32'h12, "ctrl reset");
    for (int p = 0; p < 3; p++) begin
      for (int k = 0; k < 3; k++) begin
        rd(hbpwm_pkg::PAIR0_COMPARE_A_ADDR + 32'(p) *
          hbpwm_pkg::PAIR_STRIDE + 32'(4 * k), 32'h0, "cmp reset");
      end
    end
    apb(1'b0, 32'hFFFF0FC0, 32'h0, r, e);
    `CHK("unmapped err", 1'b1, e)
    wr(hbpwm_pkg::PAIR1_COMPARE_A_ADDR, 32'h2);
    wr(hbpwm_pkg::PAIR1_COMPARE_B_ADDR, 32'h8);
    wr(hbpwm_pkg::PAIR1_COMPARE_C_ADDR, 32'h1);
    rd(hbpwm_pkg::PAIR1_COMPARE_A_ADDR, 32'h2, "cmp rw");
    wr(hbpwm_pkg::MAIN_CONTROL_ADDR, 32'h0001);
    repeat (40) @(negedge pclk);
    meas(2, 40);
    `CHK("no load hi", 0, hi)
    for (int k = 0; k < 8; k++) begin
      wr(hbpwm_pkg::MAIN_CONTROL_ADDR, 32'h9 | 32'(k << 6));
      repeat (40 << k) @(negedge pclk);
      meas(2, 40 << k);
      `CHK("high rises", 2, ri)
      `CHK("high time", 24 << k, hi)
    end
    wr(hbpwm_pkg::MAIN_CONTROL_ADDR, 32'h0029);
    repeat (40) @(negedge pclk);
    meas(2, 40);
    `CHK("high inv", 16, hi)
    meas(3, 40);
    `CHK("low inv", 32, hi)
    // pair 0: falling compare b out of reach, low wave set and cleared
    // at the same count, so the high wave stays up and the low one down
    wr(hbpwm_pkg::PAIR0_COMPARE_B_ADDR, 32'h5);
    wr(hbpwm_pkg::PAIR0_COMPARE_C_ADDR, 32'h1);
    wr(hbpwm_pkg::PAIR0_PERIOD_LENGTH_ADDR, 32'h1);
    repeat (8) @(negedge pclk);
    wr(hbpwm_pkg::MAIN_CONTROL_ADDR, 32'h0000);
    repeat (3) @(negedge pclk);
    `CHK("std off", 6'h00, outs)
    for (int i = 0; i < 7; i++) begin
      wr(hbpwm_pkg::MAIN_CONTROL_ADDR, 32'(ctl[i]));
      repeat (3) @(negedge pclk);
      `CHK("bridge", pat[i], {outs[0], outs[1], outs[2], outs[3]})
      `CHK("shoot", 1'b0, shoot)
    end
    wr(hbpwm_pkg::MAIN_CONTROL_ADDR, 32'h0401);
    @(posedge pclk);
    trip_input_n <= 1'b0;
    @(posedge pclk);
    trip_input_n <= 1'b1;
    @(negedge pclk);
    `CHK("trip irq", 1'b1, trip_irq)
    rd(hbpwm_pkg::MAIN_CONTROL_ADDR, 32'h0400, "trip ctrl");
    rd(hbpwm_pkg::TRIP_STATUS_ADDR, 32'h1, "trip stat");
    // the handler clears the pending trip before it returns
    wr(hbpwm_pkg::TRIP_INTERRUPT_CLEAR_ADDR, 32'h5A);
    @(negedge pclk);
    `CHK("trip clr", 1'b0, trip_irq)
    rd(hbpwm_pkg::TRIP_STATUS_ADDR, 32'h0, "stat clr");
    conclude();
  end
endmodule

// ==== common/hbpwm_pkg.sv ====
// package of the h-bridge pwm controller: register map, control bit
// positions and reset values.
// assumes a 32-bit apb bus that decodes the full byte address.
package hbpwm_pkg;

  // ************************************************************
  // register byte addresses
  // ************************************************************
  localparam logic [31:0] MAIN_CONTROL_ADDR = 32'hFFFF0F80;
  localparam logic [31:0] PAIR0_COMPARE_A_ADDR = 32'hFFFF0F84;
  localparam logic [31:0] PAIR0_COMPARE_B_ADDR = 32'hFFFF0F88;
  localparam logic [31:0] PAIR0_COMPARE_C_ADDR = 32'hFFFF0F8C;
  localparam logic [31:0] PAIR0_PERIOD_LENGTH_ADDR = 32'hFFFF0F90;
  localparam logic [31:0] PAIR1_COMPARE_A_ADDR = 32'hFFFF0F94;
  localparam logic [31:0] PAIR1_COMPARE_B_ADDR = 32'hFFFF0F98;
  localparam logic [31:0] PAIR1_COMPARE_C_ADDR = 32'hFFFF0F9C;
  localparam logic [31:0] PAIR1_PERIOD_LENGTH_ADDR = 32'hFFFF0FA0;
  localparam logic [31:0] PAIR2_COMPARE_A_ADDR = 32'hFFFF0FA4;
  localparam logic [31:0] PAIR2_COMPARE_B_ADDR = 32'hFFFF0FA8;
  localparam logic [31:0] PAIR2_COMPARE_C_ADDR = 32'hFFFF0FAC;
  localparam logic [31:0] PAIR2_PERIOD_LENGTH_ADDR = 32'hFFFF0FB0;
  localparam logic [31:0] TRIP_INTERRUPT_CLEAR_ADDR = 32'hFFFF0FB8;
  localparam logic [31:0] TRIP_STATUS_ADDR = 32'hFFFF0FBC;
  // distance between the register groups of two pairs
  localparam logic [31:0] PAIR_STRIDE = 32'h00000010;

  // ************************************************************
  // main_control fields
  // ************************************************************
  localparam int MASTER_OUTPUT_ENABLE_BIT = 0;
  localparam int BRIDGE_MODE_ENABLE_BIT = 1;
  localparam int DIRECTION_BIT = 2;
  localparam int COMPARE_LOAD_REQUEST_BIT = 3;
  localparam int HIGH_SIDE_OFF_BIT = 4;
  localparam int GLOBAL_OUTPUT_INVERT_BIT = 5;
  localparam int CLOCK_PRESCALE_LSB = 6;
  localparam int CLOCK_PRESCALE_MSB = 8;
  localparam int BRIDGE_OUTPUT_ENABLE_BIT = 9;
  localparam int TRIP_INTERRUPT_ENABLE_BIT = 10;
  localparam int INVERT_OUT1_BIT = 11;
  localparam int INVERT_OUT3_BIT = 12;
  localparam int INVERT_OUT5_BIT = 13;
  localparam int CONTROL_WIDTH = 16;

  // ************************************************************
  // reset values and control write mask
  // ************************************************************
  localparam logic [15:0] MAIN_CONTROL_RESET = 16'h0012;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_LENGTH_RESET = 16'hFFFF;
  localparam logic [15:0] CONTROL_WRITE_MASK = 16'h3FFF;

endpackage

// ==== verilog/hbpwm_top.sv ====
// h-bridge pwm controller: apb register file, prescaler, three pair
// counters with compare logic and the output pattern selection.
// assumes an apb master on pclk and a trip input already synchronous
// to pclk; the outputs drive an external bridge power stage.
//
// How it works
// - prescale field divides clock by 2 to 256
// - global invert flips every output in standard mode, only 4,5 in bridge mode
// - high side off forces 0,2 high, 1,3 low
// - load bit copies compares at count 0->1
// - direction picks which pair is active
// - bridge mode enables bridge control bits
// - master enable gates all outputs: low when clear, 0-3 high in bridge mode unless high side off
// - bridge enable clear drives outputs 0-3 high unless high side off
// - non-inverted bridge pattern by direction
// - inverted bridge pattern by direction
// - control resets to 0x12
// - shared pins default to pwm function
// - any write to clear register drops trip except while trip low with enable
// - high side rises at compare a, falls at b
// - low side rises at length, falls at c or high fall
// - trip low with enable clears output enable, interrupts
// - period length register bounds each counter
`timescale 1ns/1ps

module hbpwm_top #(
  parameter int PAIRS = 3,
  parameter int CNT_W = 16
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // trip input, low active
  input wire logic trip_input_n,
  // pwm outputs
  output logic channel_out_0,
  output logic channel_out_1,
  output logic channel_out_2,
  output logic channel_out_3,
  output logic channel_out_4,
  output logic channel_out_5,
  // shared pins select pwm function when high
  output logic pin_pwm_function,
  // pending trip interrupt
  output logic trip_irq
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [15:0] ctrl;
    logic [PAIRS-1:0][2:0][CNT_W-1:0] cmp_sw;
    logic [PAIRS-1:0][2:0][CNT_W-1:0] cmp_int;
    logic [PAIRS-1:0][CNT_W-1:0] len;
    logic [PAIRS-1:0][CNT_W-1:0] cnt;
    logic [PAIRS-1:0] high_w;
    logic [PAIRS-1:0] low_w;
    logic [7:0] psc;
    logic trip_pend;
    logic [5:0] outs;
    logic pin_fn;
    logic [31:0] rdata;
    logic rdy;
    logic err;
  } hbpwm_state_s;

  hbpwm_state_s st_q;
  hbpwm_state_s st_d;

  // ************************************************************
  // helpers
  // ************************************************************
  // divide code n gives a period of 2^(n+1) pclk cycles
  // the sum is widened first: a 3-bit sum would wrap code 7 to a
  // shift of zero and run the counters at the full pclk rate
  function automatic logic [7:0] hbpwm_psc_top(input logic [2:0] code);
    logic [8:0] w;
    w = 9'h001 << (4'(code) + 4'h1);
    return 8'(w - 9'h001);
  endfunction

  // which pair and which register a byte address selects
  function automatic logic hbpwm_pair_hit(input logic [31:0] a,
      input logic [31:0] base, input int p);
    return a == base + 32'(p) * hbpwm_pkg::PAIR_STRIDE;
  endfunction

  logic [15:0] ctl;
  logic tick;
  logic apb_done;
  logic apb_wr;
  logic hit;
  logic [31:0] rd;
  logic [PAIRS-1:0] high_fall;
  logic [PAIRS-1:0] high_nx;
  logic [PAIRS-1:0] low_nx;
  logic [5:0] raw;
  logic [5:0] o;
  // bridge control bits; side_off, dir and bridge_en live only while bridge_on is set
  logic bridge_on;
  logic side_off;
  logic inv;
  logic dir;
  logic bridge_en;
  logic en;

  assign ctl = st_q.ctrl;
  assign bridge_on = ctl[hbpwm_pkg::BRIDGE_MODE_ENABLE_BIT];
  assign side_off = ctl[hbpwm_pkg::HIGH_SIDE_OFF_BIT];
  assign inv = ctl[hbpwm_pkg::GLOBAL_OUTPUT_INVERT_BIT];
  assign dir = ctl[hbpwm_pkg::DIRECTION_BIT];
  assign bridge_en = ctl[hbpwm_pkg::BRIDGE_OUTPUT_ENABLE_BIT];
  assign en = ctl[hbpwm_pkg::MASTER_OUTPUT_ENABLE_BIT];
  assign apb_done = psel && penable && st_q.rdy;
  assign apb_wr = apb_done && pwrite;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_d = st_q;
    tick = 1'b0;
    hit = 1'b0;
    rd = 32'h00000000;
    high_fall = '0;
    high_nx = st_q.high_w;
    low_nx = st_q.low_w;
    raw = 6'h00;
    o = 6'h00;
    st_d.pin_fn = 1'b1;

    // prescaler: one tick per 2^(code+1) cycles
    if (st_q.psc >= hbpwm_psc_top(ctl[hbpwm_pkg::CLOCK_PRESCALE_MSB:
        hbpwm_pkg::CLOCK_PRESCALE_LSB])) begin
      st_d.psc = 8'h00;
      tick = 1'b1;
    end else begin
      st_d.psc = st_q.psc + 8'h01;
    end

    // pair counters and waveforms
    for (int p = 0; p < PAIRS; p++) begin
      if (tick) begin
        if (st_q.cnt[p] >= st_q.len[p]) begin
          st_d.cnt[p] = '0;
        end else begin
          st_d.cnt[p] = st_q.cnt[p] + CNT_W'(1);
        end
        // shadow copy on the step from zero to one
        // a zero length never steps to one, so nothing loads then
        if (st_q.cnt[p] == '0 && st_q.len[p] != '0 &&
            ctl[hbpwm_pkg::COMPARE_LOAD_REQUEST_BIT]) begin
          st_d.cmp_int[p] = st_q.cmp_sw[p];
        end
        // falling compare checked last so b wins a tie with a
        if (st_q.cnt[p] == st_q.cmp_int[p][0]) begin
          high_nx[p] = 1'b1;
        end
        if (st_q.cnt[p] == st_q.cmp_int[p][1]) begin
          high_nx[p] = 1'b0;
          high_fall[p] = st_q.high_w[p];
        end
        if (st_q.cnt[p] == st_q.len[p]) begin
          low_nx[p] = 1'b1;
        end
        if (st_q.cnt[p] == st_q.cmp_int[p][2] || high_fall[p]) begin
          low_nx[p] = 1'b0;
        end
      end
      st_d.high_w[p] = high_nx[p];
      st_d.low_w[p] = low_nx[p];
      raw[2*p] = st_q.high_w[p];
      raw[2*p+1] = st_q.low_w[p];
    end

    // output selection
    // both bridge pairs follow the pair 0 waves; pair 2 keeps its
    // standard behaviour in bridge mode too. high side off outranks the
    // bridge enable, so a motor stays off from reset until software
    // clears it. the per-output inverts come last and so also act on
    // the forced bridge patterns.
    o = raw;
    if (!bridge_on) begin
      o = raw ^ {6{inv}};
      if (!en) begin
        o = 6'h00;
      end
    end else begin
      if (en) begin
        o[5:4] = raw[5:4] ^ {2{inv}};
      end else begin
        o[5:4] = 2'b00;
      end
      if (side_off) begin
        o[3:0] = 4'b0101;
      end else if (!bridge_en || !en) begin
        o[3:0] = 4'b1111;
      end else if (!inv) begin
        // direction set makes pair 0 the active one
        o[3:0] = dir ? {2'b00, raw[1:0]} : {raw[1:0], 2'b00};
      end else begin
        o[3:0] = dir ? {raw[1:0], 2'b11} : {2'b11, raw[1:0]};
      end
    end
    o[1] = o[1] ^ ctl[hbpwm_pkg::INVERT_OUT1_BIT];
    o[3] = o[3] ^ ctl[hbpwm_pkg::INVERT_OUT3_BIT];
    o[5] = o[5] ^ ctl[hbpwm_pkg::INVERT_OUT5_BIT];
    st_d.outs = o;

    // apb read decode
    if (paddr == hbpwm_pkg::MAIN_CONTROL_ADDR) begin
      hit = 1'b1;
      rd = {16'h0000, ctl};
    end else if (paddr == hbpwm_pkg::TRIP_INTERRUPT_CLEAR_ADDR) begin
      hit = 1'b1;
    end else if (paddr == hbpwm_pkg::TRIP_STATUS_ADDR) begin
      hit = 1'b1;
      rd = {31'h00000000, st_q.trip_pend};
    end else begin
      for (int p = 0; p < PAIRS; p++) begin
        if (hbpwm_pair_hit(paddr, hbpwm_pkg::PAIR0_COMPARE_A_ADDR, p)) begin
          hit = 1'b1;
          rd = 32'(st_q.cmp_sw[p][0]);
        end else if (hbpwm_pair_hit(paddr,
            hbpwm_pkg::PAIR0_COMPARE_B_ADDR, p)) begin
          hit = 1'b1;
          rd = 32'(st_q.cmp_sw[p][1]);
        end else if (hbpwm_pair_hit(paddr,
            hbpwm_pkg::PAIR0_COMPARE_C_ADDR, p)) begin
          hit = 1'b1;
          rd = 32'(st_q.cmp_sw[p][2]);
        end else if (hbpwm_pair_hit(paddr,
            hbpwm_pkg::PAIR0_PERIOD_LENGTH_ADDR, p)) begin
          hit = 1'b1;
          rd = 32'(st_q.len[p]);
        end
      end
    end

    // apb: one wait state, answer in the second access cycle
    // the answer is registered so pready, pslverr and prdata all come
    // from flip-flops; the price is one wait state per transfer.
    // read data is zero outside the answer cycle.
    if (psel && penable && !st_q.rdy) begin
      st_d.rdy = 1'b1;
      st_d.err = !hit;
      st_d.rdata = pwrite ? 32'h00000000 : rd;
    end else begin
      st_d.rdy = 1'b0;
      st_d.err = 1'b0;
      st_d.rdata = 32'h00000000;
    end

    // apb writes take effect at the completing edge
    if (apb_wr && hit) begin
      if (paddr == hbpwm_pkg::MAIN_CONTROL_ADDR) begin
        st_d.ctrl = pwdata[15:0] & hbpwm_pkg::CONTROL_WRITE_MASK;
      end else if (paddr == hbpwm_pkg::TRIP_INTERRUPT_CLEAR_ADDR) begin
        st_d.trip_pend = 1'b0;
      end
      for (int p = 0; p < PAIRS; p++) begin
        if (hbpwm_pair_hit(paddr, hbpwm_pkg::PAIR0_COMPARE_A_ADDR, p)) begin
          st_d.cmp_sw[p][0] = pwdata[CNT_W-1:0];
        end
        if (hbpwm_pair_hit(paddr, hbpwm_pkg::PAIR0_COMPARE_B_ADDR, p)) begin
          st_d.cmp_sw[p][1] = pwdata[CNT_W-1:0];
        end
        if (hbpwm_pair_hit(paddr, hbpwm_pkg::PAIR0_COMPARE_C_ADDR, p)) begin
          st_d.cmp_sw[p][2] = pwdata[CNT_W-1:0];
        end
        if (hbpwm_pair_hit(paddr,
            hbpwm_pkg::PAIR0_PERIOD_LENGTH_ADDR, p)) begin
          st_d.len[p] = pwdata[CNT_W-1:0];
        end
      end
    end

    // trip wins over a same-cycle enable write or clear
    // the trip is a level: while it stays low the pending flag and the
    // cleared enable are re-asserted until software clears the trip enable bit
    if (!trip_input_n && ctl[hbpwm_pkg::TRIP_INTERRUPT_ENABLE_BIT]) begin
      st_d.ctrl[hbpwm_pkg::MASTER_OUTPUT_ENABLE_BIT] = 1'b0;
      st_d.trip_pend = 1'b1;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  // clk_en low holds every flop, the apb answer included, so a
  // transfer simply stretches while the clock is gated
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.ctrl <= hbpwm_pkg::MAIN_CONTROL_RESET;
      st_q.cmp_sw <= {PAIRS * 3{hbpwm_pkg::COMPARE_RESET}};
      st_q.cmp_int <= {PAIRS * 3{hbpwm_pkg::COMPARE_RESET}};
      st_q.len <= {PAIRS{hbpwm_pkg::PERIOD_LENGTH_RESET}};
      st_q.cnt <= '0;
      st_q.high_w <= '0;
      st_q.low_w <= '0;
      st_q.psc <= 8'h00;
      st_q.trip_pend <= 1'b0;
      // safe high-side-off pattern from reset on
      st_q.outs <= 6'h05;
      st_q.pin_fn <= 1'b1;
      st_q.rdata <= 32'h00000000;
      st_q.rdy <= 1'b0;
      st_q.err <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign prdata = st_q.rdata;
  assign pready = st_q.rdy;
  assign pslverr = st_q.err;
  assign channel_out_0 = st_q.outs[0];
  assign channel_out_1 = st_q.outs[1];
  assign channel_out_2 = st_q.outs[2];
  assign channel_out_3 = st_q.outs[3];
  assign channel_out_4 = st_q.outs[4];
  assign channel_out_5 = st_q.outs[5];
  assign pin_pwm_function = st_q.pin_fn;
  assign trip_irq = st_q.trip_pend;

endmodule
